// File: inc/apfp_regs.svh
/*
  Timing counts and fixed values of the asynchronous parallel byte port.
  Assumes a 50 MHz system clock on both ends of the link.
*/
`ifndef APFP_REGS_SVH
`define APFP_REGS_SVH

// system clock period
`define APFP_CLK_NS 20
// least time a flag stays inactive after a strobe cycle
`define APFP_FLAG_HOLD_NS 100
`define APFP_FLAG_HOLD_CYC ((`APFP_FLAG_HOLD_NS + `APFP_CLK_NS - 1) / `APFP_CLK_NS)
// least strobe low time
`define APFP_STROBE_NS 30
`define APFP_STROBE_MIN_CYC ((`APFP_STROBE_NS + `APFP_CLK_NS - 1) / `APFP_CLK_NS)
// least write data hold after the write strobe returns high
`define APFP_WR_HOLD_NS 5
`define APFP_WR_HOLD_CYC ((`APFP_WR_HOLD_NS + `APFP_CLK_NS - 1) / `APFP_CLK_NS)
// host strobe low length, covers the device synchroniser and output latency
`define APFP_HOST_LOW_CYC 8
// host wait after a strobe cycle before it trusts the flags again
`define APFP_HOST_GAP_CYC 8
// level of the byte bus when nobody drives it (pull-up)
`define APFP_BUS_IDLE 8'hFF
// reset values of the flags and strobes (inactive high)
`define APFP_FLAG_RST 1'b1

`endif

// File: inc/apfp_pkg.sv
/*
  Types shared by both ends of the asynchronous parallel byte port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package apfp_pkg;
  typedef logic [7:0] apfp_byte_t;
  typedef logic [2:0] apfp_hold_t;
  typedef logic [3:0] apfp_cnt_t;
  typedef enum logic [2:0] {
    APFP_H_IDLE = 3'b000,
    APFP_H_RD_LOW = 3'b001,
    APFP_H_WR_SETUP = 3'b010,
    APFP_H_WR_LOW = 3'b011,
    APFP_H_WR_HOLD = 3'b100,
    APFP_H_GAP = 3'b101
  } apfp_hstate_t;
endpackage

`default_nettype wire

// File: inc/apfp_if.sv
/*
  Pins of the asynchronous parallel byte port between device and host.
  Assumes at most one end enables its bus drivers at a time; an undriven
  bus reads as the pull-up level.
*/
`default_nettype none
`include "apfp_regs.svh"

interface apfp_if;
  logic rd_n;
  logic wr_n;
  logic rxf_n;
  logic txe_n;
  apfp_pkg::apfp_byte_t dev_dout;
  apfp_pkg::apfp_byte_t host_dout;
  apfp_pkg::apfp_byte_t bus;
  logic dev_doe;
  logic host_doe;

  // resolved level of the shared byte bus
  assign bus = dev_doe ? dev_dout : (host_doe ? host_dout : `APFP_BUS_IDLE);

  modport dev (
    input rd_n,
    input wr_n,
    input bus,
    output rxf_n,
    output txe_n,
    output dev_dout,
    output dev_doe
  );

  modport host (
    output rd_n,
    output wr_n,
    output host_dout,
    output host_doe,
    input rxf_n,
    input txe_n,
    input bus
  );
endinterface

`default_nettype wire

// File: hw/apfp_device.sv
/*
  Device end of the asynchronous parallel byte port: one byte receive
  holding register fed by the device core, one byte transmit holding
  register drained by it, flags and bus drive toward the host.
  Assumes strobes from the host are asynchronous and held low long enough
  for a two flip-flop synchroniser to see them.
*/
`default_nettype none
`include "apfp_regs.svh"

module apfp_device (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins toward the host
  apfp_if.dev link,
  // receive side feed from the device core
  input wire logic rx_valid,
  input wire apfp_pkg::apfp_byte_t rx_data,
  output logic rx_ready,
  // transmit side drain toward the device core
  output logic tx_valid,
  output apfp_pkg::apfp_byte_t tx_data,
  input wire logic tx_ready
);
  import apfp_pkg::*;

  // synchronisers and edge history
  logic rd_m_q;
  logic rd_s_q;
  logic rd_p_q;
  logic wr_m_q;
  logic wr_s_q;
  logic wr_p_q;
  apfp_byte_t bus_m_q;
  apfp_byte_t bus_s_q;

  // receive path
  apfp_byte_t cur_q;
  logic cur_vld_q;
  logic cur_vld_d;
  apfp_byte_t out_q;
  logic oe_q;
  logic rxf_n_q;
  logic rxf_n_d;
  logic rx_ready_q;
  apfp_hold_t rhold_q;
  apfp_hold_t rhold_d;

  // transmit path
  apfp_byte_t txb_q;
  logic tx_full_q;
  logic tx_full_d;
  logic txe_n_q;
  logic txe_n_d;
  apfp_hold_t whold_q;
  apfp_hold_t whold_d;

  // decoded events
  wire rd_fall;
  wire rd_rise;
  wire wr_fall;
  wire wr_rise;
  wire rx_load;
  wire rx_take;
  wire tx_cap;
  wire tx_drain;
  wire rhold_busy;
  wire whold_busy;

  // strobe edges seen after the synchroniser
  assign rd_fall = rd_p_q & ~rd_s_q;
  assign rd_rise = ~rd_p_q & rd_s_q;
  assign wr_fall = wr_p_q & ~wr_s_q;
  assign wr_rise = ~wr_p_q & wr_s_q;
  assign rhold_busy = (rhold_q != 3'h0);
  assign whold_busy = (whold_q != 3'h0);

  // receive holding register: core loads it, a read edge empties it
  assign rx_load = rx_valid & rx_ready_q;
  // fetch only while a byte is flagged as available
  assign rx_take = rd_fall & ~rxf_n_q & cur_vld_q;
  // a read edge with no byte flagged fetches nothing and re-drives the old byte
  assign cur_vld_d = rx_load | (cur_vld_q & ~rx_take);

  // flag rises on read release and stays up through the hold
  // held inactive for the minimum time after each read cycle
  // low while a byte waits outside the hold; during a read the flag keeps its value
  assign rxf_n_d = rd_rise ? 1'b1 :
                   ~rd_s_q ? rxf_n_q :
                   rhold_busy ? 1'b1 : ~cur_vld_q;
  assign rhold_d = rd_rise ? apfp_hold_t'(`APFP_FLAG_HOLD_CYC) :
                   rhold_busy ? rhold_q - 3'h1 : rhold_q;

  // capture on the write falling edge if the holding register is free
  // a write edge while the register is full drops the byte unreported;
  // the host is expected to wait for the transmit flag before writing
  assign tx_cap = wr_fall & ~tx_full_q;
  assign tx_drain = tx_full_q & tx_ready;
  assign tx_full_d = tx_cap | (tx_full_q & ~tx_drain);

  // flag high while the strobe is low and through the hold
  // low only while the holding register has room
  assign txe_n_d = ~wr_s_q | wr_rise | whold_busy | tx_full_d;
  assign whold_d = wr_rise ? apfp_hold_t'(`APFP_FLAG_HOLD_CYC) :
                   whold_busy ? whold_q - 3'h1 : whold_q;

  // two flip-flop synchronisers; the bus is delayed alongside the strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_m_q <= `APFP_FLAG_RST;
      rd_s_q <= `APFP_FLAG_RST;
      rd_p_q <= `APFP_FLAG_RST;
      wr_m_q <= `APFP_FLAG_RST;
      wr_s_q <= `APFP_FLAG_RST;
      wr_p_q <= `APFP_FLAG_RST;
      bus_m_q <= 8'h00;
      bus_s_q <= 8'h00;
    end else begin
      rd_m_q <= link.rd_n;
      rd_s_q <= rd_m_q;
      rd_p_q <= rd_s_q;
      wr_m_q <= link.wr_n;
      wr_s_q <= wr_m_q;
      wr_p_q <= wr_s_q;
      bus_m_q <= link.bus;
      bus_s_q <= bus_m_q;
    end
  end

  // receive holding register and flag
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_q <= 8'h00;
      cur_vld_q <= 1'b0;
      rx_ready_q <= 1'b0;
      rxf_n_q <= `APFP_FLAG_RST;
      rhold_q <= 3'h0;
    end else begin
      if (rx_load) begin
        cur_q <= rx_data;
      end
      cur_vld_q <= cur_vld_d;
      rx_ready_q <= ~cur_vld_d;
      rxf_n_q <= rxf_n_d;
      rhold_q <= rhold_d;
    end
  end

  // bus drive: byte taken at the read edge, enable follows the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      if (rx_take) begin
        out_q <= cur_q;
      end
      oe_q <= ~rd_s_q;
    end
  end

  // transmit holding register and flag
  always_ff @(posedge clk) begin
    if (rst) begin
      txb_q <= 8'h00;
      tx_full_q <= 1'b0;
      txe_n_q <= `APFP_FLAG_RST;
      whold_q <= 3'h0;
    end else begin
      if (tx_cap) begin
        txb_q <= bus_s_q;
      end
      tx_full_q <= tx_full_d;
      txe_n_q <= txe_n_d;
      whold_q <= whold_d;
    end
  end

  // pins and core-side outputs, all straight from flip-flops
  assign link.rxf_n = rxf_n_q;
  assign link.txe_n = txe_n_q;
  assign link.dev_dout = out_q;
  assign link.dev_doe = oe_q;
  assign rx_ready = rx_ready_q;
  assign tx_valid = tx_full_q;
  assign tx_data = txb_q;
endmodule

`default_nettype wire

// File: hw/apfp_host.sv
/*
  Host end of the asynchronous parallel byte port: issues one read or one
  write strobe cycle at a time, paced by the device flags.
  Assumes the device flags are asynchronous to this clock and that the
  device releases the bus within a few cycles of the read strobe rising.
*/
`default_nettype none
`include "apfp_regs.svh"

module apfp_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins toward the device
  apfp_if.host link,
  // read requests and received bytes
  input wire logic rd_en,
  output logic rx_valid,
  output apfp_pkg::apfp_byte_t rx_data,
  // write requests
  input wire logic wr_valid,
  input wire apfp_pkg::apfp_byte_t wr_data,
  output logic wr_done
);
  import apfp_pkg::*;

  logic rxf_m_q;
  logic rxf_s_q;
  logic txe_m_q;
  logic txe_s_q;
  apfp_byte_t bus_m_q;
  apfp_byte_t bus_s_q;
  apfp_hstate_t st_q;
  apfp_cnt_t cnt_q;
  logic rd_n_q;
  logic wr_n_q;
  apfp_byte_t dout_q;
  logic doe_q;
  logic rx_valid_q;
  apfp_byte_t rx_data_q;
  logic wr_done_q;

  wire cnt_zero;
  wire go_rd;
  wire go_wr;

  assign cnt_zero = (cnt_q == 4'h0);
  // strobe only while the matching flag is seen low
  assign go_rd = rd_en & ~rxf_s_q;
  assign go_wr = wr_valid & ~txe_s_q & ~go_rd;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxf_m_q <= `APFP_FLAG_RST;
      rxf_s_q <= `APFP_FLAG_RST;
      txe_m_q <= `APFP_FLAG_RST;
      txe_s_q <= `APFP_FLAG_RST;
      bus_m_q <= 8'h00;
      bus_s_q <= 8'h00;
    end else begin
      rxf_m_q <= link.rxf_n;
      rxf_s_q <= rxf_m_q;
      txe_m_q <= link.txe_n;
      txe_s_q <= txe_m_q;
      bus_m_q <= link.bus;
      bus_s_q <= bus_m_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= APFP_H_IDLE;
      cnt_q <= 4'h0;
      rd_n_q <= `APFP_FLAG_RST;
      wr_n_q <= `APFP_FLAG_RST;
      dout_q <= 8'h00;
      doe_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_data_q <= 8'h00;
      wr_done_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      wr_done_q <= 1'b0;
      if (!cnt_zero) begin
        cnt_q <= cnt_q - 4'h1;
      end
      unique case (st_q)
        APFP_H_IDLE: begin
          if (go_rd) begin
            rd_n_q <= 1'b0;
            cnt_q <= apfp_cnt_t'(`APFP_HOST_LOW_CYC - 1);
            st_q <= APFP_H_RD_LOW;
          end else if (go_wr) begin
            dout_q <= wr_data;
            doe_q <= 1'b1;
            st_q <= APFP_H_WR_SETUP;
          end
        end
        APFP_H_RD_LOW: begin
          // low for well over the least strobe width
          if (cnt_zero) begin
            rd_n_q <= 1'b1;
            rx_data_q <= bus_s_q;
            rx_valid_q <= 1'b1;
            cnt_q <= apfp_cnt_t'(`APFP_HOST_GAP_CYC - 1);
            st_q <= APFP_H_GAP;
          end
        end
        APFP_H_WR_SETUP: begin
          wr_n_q <= 1'b0;
          cnt_q <= apfp_cnt_t'(`APFP_HOST_LOW_CYC - 1);
          st_q <= APFP_H_WR_LOW;
        end
        APFP_H_WR_LOW: begin
          if (cnt_zero) begin
            wr_n_q <= 1'b1;
            cnt_q <= apfp_cnt_t'(`APFP_WR_HOLD_CYC - 1);
            st_q <= APFP_H_WR_HOLD;
          end
        end
        APFP_H_WR_HOLD: begin
          // data stays on the bus past the strobe release
          if (cnt_zero) begin
            doe_q <= 1'b0;
            wr_done_q <= 1'b1;
            cnt_q <= apfp_cnt_t'(`APFP_HOST_GAP_CYC - 1);
            st_q <= APFP_H_GAP;
          end
        end
        APFP_H_GAP: begin
          // stale low flags are not trusted until the device has raised them
          if (cnt_zero) begin
            st_q <= APFP_H_IDLE;
          end
        end
        default: begin
          st_q <= APFP_H_IDLE;
        end
      endcase
    end
  end

  assign link.rd_n = rd_n_q;
  assign link.wr_n = wr_n_q;
  assign link.host_dout = dout_q;
  assign link.host_doe = doe_q;
  assign rx_valid = rx_valid_q;
  assign rx_data = rx_data_q;
  assign wr_done = wr_done_q;
endmodule

`default_nettype wire

// File: tb/apfp_link_assertions.sv
/*
  Concurrent checks on the pins between the two ends of the parallel byte port.
  Assumes it is instantiated beside the link interface and fed its signals.
*/
`default_nettype none

module apfp_link_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // strobes and flags
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic rxf_n,
  input wire logic txe_n,
  // bus drive of both ends
  input wire apfp_pkg::apfp_byte_t dev_dout,
  input wire logic dev_doe,
  input wire logic host_doe
);
  import apfp_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd_fall; $fell(rd_n); endsequence
  sequence s_rd_rise; $rose(rd_n); endsequence
  sequence s_wr_fall; $fell(wr_n); endsequence
  sequence s_wr_rise; $rose(wr_n); endsequence

  AST_ONE_STROBE: assert property (rd_n || wr_n)
    else $error("both strobes low together");
  AST_RD_WHEN_AVAIL: assert property (s_rd_fall |-> !$past(rxf_n))
    else $error("read started while no byte waits");
  AST_WR_WHEN_SPACE: assert property (s_wr_fall |-> !$past(txe_n))
    else $error("write started while no space");
  AST_RD_DRIVES: assert property (s_rd_fall |-> ##[1:3] dev_doe)
    else $error("device did not drive bus during read");
  AST_DOE_FROM_RD: assert property ($rose(dev_doe) |-> !rd_n && !$past(rd_n))
    else $error("bus enable not caused by read strobe");
  AST_RD_RELEASE: assert property (s_rd_rise |-> ##[1:3] (!dev_doe && rxf_n))
    else $error("bus or receive flag not released after read");
  AST_RD_DATA_STEADY: assert property (dev_doe && $past(dev_doe) |-> $stable(dev_dout))
    else $error("read byte changed while driven");
  AST_TXE_ON_WR: assert property (s_wr_fall |-> ##[1:3] txe_n)
    else $error("transmit flag not raised by write");
  AST_RXF_HOLD: assert property ($rose(rxf_n) |-> rxf_n [*5])
    else $error("receive flag inactive too short");
  AST_TXE_HOLD: assert property (s_wr_rise |-> txe_n [*5])
    else $error("transmit flag inactive too short");
  AST_RD_WIDTH: assert property (s_rd_fall |-> !rd_n [*2])
    else $error("read strobe too short");
  AST_WR_WIDTH: assert property (s_wr_fall |-> !wr_n [*2])
    else $error("write strobe too short");
  AST_WR_HOLD: assert property (s_wr_rise |-> host_doe)
    else $error("write data released with strobe");
endmodule

`default_nettype wire

// File: tb/tb_async_parallel_byte_fifo_port.sv
/*
  Self-checking bench joining device and host ends over the link interface.
  Assumes both ends run on one 50 MHz clock with synchronous reset.
*/
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
`define WAIT(c) begin for (w = 0; w < 400 && ((c) !== 1'b1); w++) @(negedge clk); \
  if ((c) !== 1'b1) begin mismatches++; report_and_stop(); end end

module tb_async_parallel_byte_fifo_port;
  timeunit 1ns;
  timeprecision 1ps;
  import apfp_pkg::*;

  logic clk, rst, rx_valid, rx_ready, tx_valid, tx_ready;
  logic rd_en, h_rx_valid, wr_valid, wr_done;
  apfp_byte_t rx_data, tx_data, h_rx_data, wr_data;
  int mismatches = 0;
  int total_checks = 0;

  apfp_if link_if();

  apfp_device i_apfp_device (.clk(clk), .rst(rst), .link(link_if.dev),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  apfp_host i_apfp_host (.clk(clk), .rst(rst), .link(link_if.host),
    .rd_en(rd_en), .rx_valid(h_rx_valid), .rx_data(h_rx_data),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_done(wr_done));

  apfp_link_assertions i_apfp_link_assertions (.clk(clk), .rst(rst),
    .rd_n(link_if.rd_n), .wr_n(link_if.wr_n), .rxf_n(link_if.rxf_n),
    .txe_n(link_if.txe_n), .dev_dout(link_if.dev_dout),
    .dev_doe(link_if.dev_doe), .host_doe(link_if.host_doe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // core offers one byte to the device
  task automatic put_rx(apfp_byte_t b);
    int w;
    rx_valid = 1'b1;
    rx_data = b;
    `WAIT(rx_ready)
    @(negedge clk);
    rx_valid = 1'b0;
  endtask

  task automatic get_rx(apfp_byte_t exp);
    int w;
    `WAIT(h_rx_valid)
    `CHK(h_rx_data, exp)
    @(negedge clk);
  endtask

  task automatic put_wr(apfp_byte_t b);
    int w;
    wr_valid = 1'b1;
    wr_data = b;
    `WAIT(wr_done)
    wr_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic take_tx(apfp_byte_t exp);
    int w;
    `WAIT(tx_valid)
    `CHK(tx_data, exp)
    tx_ready = 1'b1;
    @(negedge clk);
    tx_ready = 1'b0;
  endtask

  task automatic t_reset();
    int w;
    repeat (4) @(negedge clk);
    `CHK({link_if.rd_n, link_if.wr_n, link_if.rxf_n, link_if.txe_n}, 4'hf)
    `CHK({link_if.dev_doe, link_if.host_doe}, 2'h0)
    rst = 1'b0;
    `WAIT(link_if.txe_n === 1'b0)
    `CHK(link_if.rxf_n, 1'b1)
    $display("test reset done");
  endtask

  // byte waits while the host may not read: bus stays released
  task automatic t_read_gated();
    logic seen;
    seen = 1'b0;
    put_rx(8'h96);
    repeat (30) begin
      @(negedge clk);
      seen = seen | h_rx_valid;
    end
    `CHK(link_if.rxf_n, 1'b0)
    `CHK(seen, 1'b0)
    `CHK(link_if.bus, 8'hff)
    rd_en = 1'b1;
    get_rx(8'h96);
    $display("test read gated done");
  endtask

  // second byte only fits once the first is fetched by the read strobe
  task automatic t_read_pair();
    put_rx(8'ha5);
    put_rx(8'h5a);
    get_rx(8'ha5);
    get_rx(8'h5a);
    $display("test read pair done");
  endtask

  // transmit register full: second write must wait for the flag
  task automatic t_write_stall();
    int w;
    logic seen;
    seen = 1'b0;
    put_wr(8'h3c);
    wr_valid = 1'b1;
    wr_data = 8'hc3;
    repeat (40) begin
      @(negedge clk);
      seen = seen | wr_done;
    end
    `CHK(seen, 1'b0)
    `CHK(link_if.txe_n, 1'b1)
    take_tx(8'h3c);
    `WAIT(wr_done)
    wr_valid = 1'b0;
    @(negedge clk);
    take_tx(8'hc3);
    $display("test write stall done");
  endtask

  // traffic in both directions at once
  task automatic t_both_ways();
    fork
      put_wr(8'h18);
      begin
        put_rx(8'h81);
        get_rx(8'h81);
      end
    join
    take_tx(8'h18);
    $display("test both ways done");
  endtask

  initial begin
    rst = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    rd_en = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    t_reset();
    t_read_gated();
    t_read_pair();
    t_write_stall();
    t_both_ways();
    report_and_stop();
  end
endmodule

`default_nettype wire
